// >>> src/slc_pkg.sv
package slc_pkg;
    // register addresses, byte wide registers on a 12-bit port
    localparam logic [11:0] ADDR_TS_CTRL = 12'h160;
    localparam logic [11:0] ADDR_LINK_EN = 12'h200;
    localparam logic [11:0] ADDR_MODE = 12'h201;
    localparam logic [11:0] ADDR_KM1 = 12'h202;
    localparam logic [11:0] ADDR_MSYNC = 12'h203;
    localparam logic [11:0] ADDR_CTRL = 12'h204;
    localparam logic [11:0] ADDR_STATUS = 12'h210;
    // reset values
    localparam logic [7:0] RST_TS_CTRL = 8'h00;
    localparam logic [7:0] RST_LINK_EN = 8'h01;
    localparam logic [7:0] RST_MODE = 8'h02;
    localparam logic [7:0] RST_KM1 = 8'h1f;
    localparam logic [7:0] RST_MSYNC = 8'h01;
    localparam logic [1:0] RST_SYNC_SEL = 2'h0;
    // field positions in the control register at ADDR_CTRL
    localparam int SYNC_SEL_LO = 2;
    // sync source codes
    localparam logic [1:0] SYNC_SRC_DED = 2'h0;
    localparam logic [1:0] SYNC_SRC_TS = 2'h1;
    localparam logic [1:0] SYNC_SRC_NONE = 2'h2;
    // stages of the sample delay line, in cycles; the output flop adds one more
    localparam int PIPE_LAT = 3;
    // 64b/66b multiframe base figure
    localparam int MF_BASE = 256;
endpackage

// >>> src/slc_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module slc_regs #(
    parameter int ADDR_W = 12, // register address width
    parameter int SMP_W = 12 // sample width
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // register port
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // mode lock and mode facts from the mode table
    input wire logic [255:0] I_MODE_ALLOWED,
    input wire logic I_MODE_IS_64B66B,
    input wire logic I_NARROW_8BIT,
    input wire logic [7:0] I_MODE_E,
    input wire logic [7:0] I_MODE_F,
    // sample path
    input wire logic [SMP_W-1:0] I_SAMPLE,
    input wire logic I_TIMESTAMP,
    output logic [SMP_W-1:0] O_SAMPLE,
    // dedicated sync pin and sync request output, active low
    input wire logic I_DEDICATED_SYNC_N,
    output logic O_SYNC_REQ_N,
    // link control
    output logic O_LINK_RESET,
    output logic O_SERDES_PD,
    output logic O_LINK_CLK_EN,
    output logic O_LMFC_RESET,
    output logic [7:0] O_LINK_MODE,
    output logic [15:0] O_FRAMES_PER_MF,
    output logic [7:0] O_ILA_CS,
    output logic O_TS_RECV_EN
);
    import slc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic ts_en; // timestamp insert enable
        logic link_en; // subsystem enable
        logic [7:0] mode; // link mode select as written
        logic [7:0] mode_eff; // link mode in effect
        logic [7:0] km1; // frames per multiframe minus one
        logic msync; // manual sync request, low requests
        logic [1:0] sync_sel; // sync source selector
        logic [7:0] rdata; // read data
        // delay lines are packed so the whole state stays one vector
        // stage 0 takes the pin, the last stage feeds the output flop
        logic [PIPE_LAT-1:0][SMP_W-1:0] smp; // sample delay line
        logic [PIPE_LAT-1:0] ts; // timestamp delay line
        logic [SMP_W-1:0] out; // output sample
        logic sync_n; // effective sync request
    } slc_state_t;
    slc_state_t s_q, s_d;

    // address compare used by reads and writes
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] r);
        hit = (a == r[ADDR_W-1:0]);
    endfunction

    logic pin_n; // selected sync pin level
    logic [15:0] k64; // 64b/66b frame count

    ////////////////////////////////////////////////////////////////////////////
    // next state
    // every register write lands at the edge that samples the strobe
    // a read answers from the registers as they stood before that edge
    // the sample path runs while software touches the registers
    // the disabled link overrides the sample path and the sync request
    // mode lock is applied one cycle after the mode register changes
    always_comb
    begin
        s_d = s_q;
        // register writes
        if (I_WR)
        begin
            if (hit(I_ADDR, ADDR_TS_CTRL)) s_d.ts_en = I_WDATA[0];
            if (hit(I_ADDR, ADDR_LINK_EN)) s_d.link_en = I_WDATA[0];
            if (hit(I_ADDR, ADDR_MODE)) s_d.mode = I_WDATA;
            if (hit(I_ADDR, ADDR_KM1)) s_d.km1 = I_WDATA;
            if (hit(I_ADDR, ADDR_MSYNC)) s_d.msync = I_WDATA[0];
            if (hit(I_ADDR, ADDR_CTRL)) s_d.sync_sel = I_WDATA[SYNC_SEL_LO +: 2];
        end
        // only allowed modes take effect
        if (I_MODE_ALLOWED[s_q.mode]) s_d.mode_eff = s_q.mode;
        // register reads, unmapped reads zero
        s_d.rdata = 8'h00;
        if (I_RD)
        begin
            if (hit(I_ADDR, ADDR_TS_CTRL)) s_d.rdata = {7'h00, s_q.ts_en};
            else if (hit(I_ADDR, ADDR_LINK_EN)) s_d.rdata = {7'h00, s_q.link_en};
            else if (hit(I_ADDR, ADDR_MODE)) s_d.rdata = s_q.mode;
            else if (hit(I_ADDR, ADDR_KM1)) s_d.rdata = s_q.km1;
            else if (hit(I_ADDR, ADDR_MSYNC)) s_d.rdata = {7'h00, s_q.msync};
            else if (hit(I_ADDR, ADDR_CTRL)) s_d.rdata = {4'h0, s_q.sync_sel, 2'h0};
            else if (hit(I_ADDR, ADDR_STATUS)) s_d.rdata = {7'h00, s_q.sync_n};
        end
        // sample and timestamp travel delay lines of the same depth
        s_d.smp[0] = I_SAMPLE;
        s_d.ts[0] = I_TIMESTAMP;
        for (int i = 1; i < PIPE_LAT; i++)
        begin
            s_d.smp[i] = s_q.smp[i-1];
            s_d.ts[i] = s_q.ts[i-1];
        end
        // lsb replacement, 8-bit samples sit in the top byte
        s_d.out = s_q.smp[PIPE_LAT-1];
        if (s_q.ts_en)
        begin
            if (I_NARROW_8BIT) s_d.out[SMP_W-8] = s_q.ts[PIPE_LAT-1];
            else s_d.out[0] = s_q.ts[PIPE_LAT-1];
        end
        // sync source selection
        unique case (s_q.sync_sel)
            SYNC_SRC_DED: pin_n = I_DEDICATED_SYNC_N;
            SYNC_SRC_TS: pin_n = I_TIMESTAMP;
            default: pin_n = 1'b1;
        endcase
        s_d.sync_n = s_q.msync & pin_n;
        // held off while the link is disabled
        if (!s_q.link_en)
        begin
            s_d.smp = '0;
            s_d.ts = '0;
            s_d.out = '0;
            s_d.sync_n = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    // asynchronous reset loads constants only
    // the run path copies the whole next-state vector in one go
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            s_q.ts_en <= RST_TS_CTRL[0];
            s_q.link_en <= RST_LINK_EN[0];
            s_q.mode <= RST_MODE;
            s_q.mode_eff <= RST_MODE;
            s_q.km1 <= RST_KM1;
            s_q.msync <= RST_MSYNC[0];
            s_q.sync_sel <= RST_SYNC_SEL;
            s_q.rdata <= 8'h00;
            s_q.smp <= '0;
            s_q.ts <= '0;
            s_q.out <= '0;
            s_q.sync_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    // link control levels follow the enable bit with no extra delay
    // so reset, power down and clock gating switch together
    // 64b/66b multiframe length from the mode's E and F
    always_comb
    begin
        k64 = 16'h0000;
        if (I_MODE_F != 8'h00)
            k64 = 16'((MF_BASE * int'(I_MODE_E)) / int'(I_MODE_F));
    end
    assign O_FRAMES_PER_MF = I_MODE_IS_64B66B ? k64 : {8'h00, s_q.km1} + 16'h0001;
    assign O_RDATA = s_q.rdata;
    assign O_SAMPLE = s_q.out;
    assign O_SYNC_REQ_N = s_q.sync_n;
    assign O_LINK_RESET = !s_q.link_en;
    assign O_SERDES_PD = !s_q.link_en;
    assign O_LINK_CLK_EN = s_q.link_en;
    assign O_LMFC_RESET = !s_q.link_en;
    assign O_LINK_MODE = s_q.mode_eff;
    assign O_ILA_CS = 8'h00;
    assign O_TS_RECV_EN = s_q.ts_en;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // properties watch the registered state and the block's outputs
    // all of them are quiet while reset is held
    // five steady cycles cover capture, three stages and the output flop
    sequence seq_ts_wide;
        (s_q.ts_en && s_q.link_en && !I_NARROW_8BIT) [*5];
    endsequence
    sequence seq_ts_narrow;
        (s_q.ts_en && s_q.link_en && I_NARROW_8BIT) [*5];
    endsequence
    sequence seq_req_written;
        I_WR && hit(I_ADDR, ADDR_MSYNC) && !I_WDATA[0];
    endsequence
    AST_MSYNC_REQ: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        seq_req_written ##1 s_q.link_en |=> !O_SYNC_REQ_N)
        else $error("manual sync did not request");
    AST_AND: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        s_q.link_en |=> O_SYNC_REQ_N == ($past(s_q.msync) & $past(pin_n)))
        else $error("sync request not and of sources");
    AST_SRC2: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        s_q.sync_sel == SYNC_SRC_NONE && s_q.msync ##1 1'b1 |-> O_SYNC_REQ_N)
        else $error("source 2 still requests");
    AST_TS_LSB: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        seq_ts_wide |-> O_SAMPLE[0] == $past(I_TIMESTAMP, 4))
        else $error("timestamp latency mismatch");
    // narrow samples carry the stamp at the lsb of the top byte
    AST_TS_NARROW: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        seq_ts_narrow |-> O_SAMPLE[SMP_W-8] == $past(I_TIMESTAMP, 4))
        else $error("narrow timestamp misplaced");
    // insertion off leaves the sample lsb untouched
    AST_TS_OFF: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !s_q.ts_en && s_q.link_en |=> O_SAMPLE[0] == $past(s_q.smp[PIPE_LAT-1][0]))
        else $error("lsb changed with insertion off");
    // disabled link zeroes samples and drops the request
    AST_OFF_SAMPLE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !s_q.link_en |=> (O_SAMPLE == '0) && O_SYNC_REQ_N)
        else $error("disabled link still active");
    // a stuck dedicated pin keeps the request up
    AST_SRC_DED: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        s_q.link_en && s_q.sync_sel == SYNC_SRC_DED && !I_DEDICATED_SYNC_N |=> !O_SYNC_REQ_N)
        else $error("dedicated pin request lost");
    // code 1 routes the timestamp pin as sync
    AST_SRC_TS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        s_q.link_en && s_q.sync_sel == SYNC_SRC_TS && !I_TIMESTAMP |=> !O_SYNC_REQ_N)
        else $error("timestamp pin request lost");
    // manual bit requests whatever source is selected
    AST_MANUAL_ANY: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        s_q.link_en && !s_q.msync |=> !O_SYNC_REQ_N)
        else $error("manual request lost");
    // an allowed mode takes effect one cycle later
    AST_MODE_TAKEN: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_MODE_ALLOWED[s_q.mode] |=> O_LINK_MODE == $past(s_q.mode))
        else $error("allowed mode not taken");
    // a locked mode leaves the mode in effect alone
    AST_MODE_REFUSED: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !I_MODE_ALLOWED[s_q.mode] |=> $stable(O_LINK_MODE))
        else $error("locked mode changed the link");
    // enable bit follows its write
    AST_LINK_EN_WR: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_WR && hit(I_ADDR, ADDR_LINK_EN) |=> s_q.link_en == $past(I_WDATA[0]))
        else $error("enable write lost");
    // mode register takes all eight bits
    AST_MODE_WR: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_WR && hit(I_ADDR, ADDR_MODE) |=> s_q.mode == $past(I_WDATA))
        else $error("mode write lost");
    // multiframe register takes all eight bits
    AST_KM1_WR: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_WR && hit(I_ADDR, ADDR_KM1) |=> s_q.km1 == $past(I_WDATA))
        else $error("multiframe write lost");
    // counter reset stands for as long as the link is off
    AST_LMFC_HELD: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !s_q.link_en |-> O_LMFC_RESET)
        else $error("lmfc reset dropped");
    // read data only stand in the cycle after a read
    AST_RDATA_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !I_RD |=> O_RDATA == 8'h00)
        else $error("read data outside read slot");
    AST_KM1: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !I_MODE_IS_64B66B |-> O_FRAMES_PER_MF == {8'h00, s_q.km1} + 16'h0001)
        else $error("frame count wrong");
    AST_DISABLED: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !s_q.link_en |-> O_LINK_RESET && O_SERDES_PD && !O_LINK_CLK_EN)
        else $error("disabled link not held");
    AST_LMFC: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        $fell(s_q.link_en) |-> O_LMFC_RESET)
        else $error("lmfc not held");
    AST_ILA: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_ILA_CS == 8'h00)
        else $error("ila control bits nonzero");
    AST_LOCK: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        $changed(O_LINK_MODE) |-> I_MODE_ALLOWED[O_LINK_MODE])
        else $error("locked mode took effect");
endmodule // slc_regs

// >>> dv/slc_sync_rx_model.sv
`timescale 1ns/10ps
// far-end receiver model, owns the active-low sync pin
module slc_sync_rx_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // bench asks the receiver to lose alignment
    input wire logic i_want_sync,
    output logic o_sync_n
);
    // pin idles high, goes low one cycle after realignment is wanted
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_sync_n <= 1'b1;
        else
            o_sync_n <= !i_want_sync;
    end
endmodule // slc_sync_rx_model

// >>> dv/serial_link_control_regs_tb.sv
`timescale 1ns/10ps
module serial_link_control_regs_tb;
    import slc_pkg::*;
    logic clk, rst_n, wr, rd, ts, want_sync, ded_n, i8, b64;
    logic sreq_n, lrst, pd, cken, lmfc, tsrx;
    logic [11:0] addr, smp, osmp;
    logic [7:0] wd, rdata, mode, ila, e, f;
    logic [255:0] allowed;
    logic [15:0] fpm, prev, ex;
    int miscompares, checks_done, cycles;
    logic [11:0] s_tab [3] = '{12'hc3b, 12'h5a4, 12'h5a4}; // sample per case
    logic [2:0] t_tab = 3'b110; // timestamp per case, bit n is case n
    logic [2:0] n_tab = 3'b100; // narrow mode per case
    slc_regs dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_MODE_ALLOWED(allowed), .I_MODE_IS_64B66B(b64),
        .I_NARROW_8BIT(i8), .I_MODE_E(e), .I_MODE_F(f), .I_SAMPLE(smp), .I_TIMESTAMP(ts),
        .O_SAMPLE(osmp), .I_DEDICATED_SYNC_N(ded_n), .O_SYNC_REQ_N(sreq_n),
        .O_LINK_RESET(lrst), .O_SERDES_PD(pd), .O_LINK_CLK_EN(cken), .O_LMFC_RESET(lmfc),
        .O_LINK_MODE(mode), .O_FRAMES_PER_MF(fpm), .O_ILA_CS(ila), .O_TS_RECV_EN(tsrx));
    slc_sync_rx_model rx (.i_clk(clk), .i_rst_n(rst_n), .i_want_sync(want_sync),
        .o_sync_n(ded_n));
    ////////////////////////////////////////////////////////////////////////////////
    // compare and count, report a miss at once
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // wait n edges, then let them settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one-cycle register write
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // one-cycle read, data judged in the following cycle only
    task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
        tick(1);
        chk("rdata_gone", rdata, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // reset values, unmapped read, idle outputs
    task automatic t_reset();
        rreg(ADDR_LINK_EN, 8'h01);
        rreg(ADDR_MODE, 8'h02);
        rreg(ADDR_KM1, 8'h1f);
        rreg(ADDR_MSYNC, 8'h01);
        rreg(ADDR_TS_CTRL, 8'h00);
        rreg(12'h2ff, 8'h00);
        chk("frames", fpm, 16'h0020);
        chk("ila_cs", ila, 16'h0000);
    endtask
    // timestamp in the sample lsb, exactly the sample latency
    task automatic t_ts();
        wreg(ADDR_TS_CTRL, 8'h01);
        tick(1);
        chk("ts_recv", tsrx, 16'h0001);
        prev = 16'h0000;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            smp <= s_tab[k];
            ts <= t_tab[k];
            i8 <= n_tab[k];
            ex = n_tab[k] ? {4'h0, s_tab[k][11:5], t_tab[k], s_tab[k][3:0]}
                          : {4'h0, s_tab[k][11:1], t_tab[k]};
            tick(3);
            if (k < 2)
                chk("sample_old", osmp, prev);
            tick(1);
            chk("sample", osmp, ex);
            prev = ex;
        end
        wreg(ADDR_TS_CTRL, 8'h00);
    endtask
    // disabled link state, multiframe count, mode lock
    task automatic t_link();
        wreg(ADDR_LINK_EN, 8'h00);
        tick(2);
        chk("link_rst", {lrst, pd, cken, lmfc, sreq_n}, 16'h001b);
        chk("zeroed", osmp, 16'h0000);
        wreg(ADDR_KM1, 8'h0f);
        tick(1);
        chk("frames", fpm, 16'h0010);
        b64 <= 1'b1;
        tick(1);
        chk("frames_64", fpm, 16'h0080);
        b64 <= 1'b0;
        wreg(ADDR_MODE, 8'h05);
        tick(2);
        chk("mode", mode, 16'h0005);
        wreg(ADDR_MODE, 8'h07);
        tick(2);
        chk("mode_lock", mode, 16'h0005);
        wreg(ADDR_LINK_EN, 8'h01);
        tick(2);
        chk("link_on", {lrst, pd, cken, lmfc}, 16'h0002);
    endtask
    // every source code with manual bit and pin, unselected pin stuck low
    task automatic t_sync();
        for (int c = 0; c < 12; c++)
        begin
            wreg(ADDR_CTRL, {4'h0, c[3:2], 2'b00});
            wreg(ADDR_MSYNC, {7'h00, c[1]});
            want_sync <= (c[3:2] == 2'd0) ? !c[0] : 1'b1;
            ts <= (c[3:2] == 2'd1) ? c[0] : 1'b0;
            tick(4);
            ex = {15'h0000, c[1] & ((c[3:2] == 2'd2) | c[0])};
            chk("sync_req", sreq_n, ex);
            rreg(ADDR_STATUS, ex[7:0]);
        end
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // main sequence, modes 2 and 5 unlocked
    initial
    begin
        {rst_n, wr, rd, ts, want_sync, i8, b64, addr, smp, wd} = '0;
        {allowed, e, f} = {256'h24, 8'h02, 8'h04};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ts();
        t_link();
        t_sync();
        stop_test();
    end
endmodule // serial_link_control_regs_tb
